// File: src/rtv_pkg.sv
package rtv_pkg;

   // Register byte offsets on the bus
   localparam logic [11:0] RTV_OFF_CTRL   = 12'h000;
   localparam logic [11:0] RTV_OFF_TIME   = 12'h004;
   localparam logic [11:0] RTV_OFF_ALARM  = 12'h008;
   localparam logic [11:0] RTV_OFF_STATUS = 12'h00C;

   // Control register field positions
   localparam int RTV_CTRL_WREN_POS = 0;
   localparam int RTV_CTRL_APTR_POS = 8;
   localparam int RTV_CTRL_TPTR_POS = 16;

   // Status register field positions
   localparam int RTV_STAT_VALID_POS = 0;
   localparam int RTV_STAT_MATCH_POS = 8;

   // Window pointer codes
   localparam logic [1:0] RTV_PTR_MINSEC = 2'h0;
   localparam logic [1:0] RTV_PTR_WDHR   = 2'h1;
   localparam logic [1:0] RTV_PTR_MTHDAY = 2'h2;

   // Value field positions
   localparam int RTV_MIN_TEN_POS = 12;
   localparam int RTV_MIN_ONE_POS = 8;
   localparam int RTV_SEC_TEN_POS = 4;
   localparam int RTV_SEC_ONE_POS = 0;
   localparam int RTV_MTH_TEN_POS = 12;
   localparam int RTV_MTH_ONE_POS = 8;
   localparam int RTV_DAY_TEN_POS = 4;
   localparam int RTV_DAY_ONE_POS = 0;
   localparam int RTV_WEEKDAY_DIGIT_POS    = 8;
   localparam int RTV_HR_TEN_POS  = 4;
   localparam int RTV_HR_ONE_POS  = 0;

   // Implemented bits of each value register
   localparam logic [15:0] RTV_MASK_MINSEC = 16'h7F7F;
   localparam logic [15:0] RTV_MASK_MTHDAY = 16'h1F3F;
   localparam logic [15:0] RTV_MASK_WDHR   = 16'h073F;

   // Reset values
   localparam logic [15:0] RTV_VALUE_RST = 16'h0000;
   localparam logic [1:0]  RTV_PTR_RST   = 2'h0;
   localparam logic        RTV_WREN_RST  = 1'b0;
   localparam logic [31:0] RTV_RDATA_RST = 32'h0000_0000;

endpackage

// File: src/rtv_req_if.sv
`timescale 1ns/1ns
interface rtv_req_if;
   logic        req_wr;
   logic        req_rd;
   logic [11:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;

   modport front (output req_wr, output req_rd, output addr, output wdata, input rdata);
   modport core  (input req_wr, input req_rd, input addr, input wdata, output rdata);
endinterface

// File: src/rtv_ahb_front.sv
`timescale 1ns/1ns
module rtv_ahb_front
   import rtv_pkg::*;
(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave side
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   // Request carrier to the core
   rtv_req_if.front         req
);

   typedef enum logic [1:0] {RTV_IDLE, RTV_DATA, RTV_RESP} rtv_fsm_t;

   typedef struct packed {
      rtv_fsm_t    fsm;
      logic        wr;
      logic [11:0] addr;
      logic [31:0] rdata;
      logic        ready;
   } rtv_front_t;

   rtv_front_t st_reg;
   rtv_front_t st_next;

   // One wait state so read data leave from a flop
   always_comb begin
      st_next = st_reg;
      req.req_wr = 1'b0;
      req.req_rd = 1'b0;
      req.addr   = st_reg.addr;
      req.wdata  = hwdata;
      unique case (st_reg.fsm)
         RTV_IDLE: begin
            if (hsel && hready && htrans[1]) begin
               st_next.fsm   = RTV_DATA;
               st_next.wr    = hwrite;
               st_next.addr  = haddr[11:0];
               st_next.ready = 1'b0;
            end
         end
         RTV_DATA: begin
            req.req_wr    = st_reg.wr;
            req.req_rd    = !st_reg.wr;
            st_next.rdata = st_reg.wr ? RTV_RDATA_RST : req.rdata;
            st_next.ready = 1'b1;
            st_next.fsm   = RTV_RESP;
         end
         RTV_RESP: begin
            st_next.fsm = RTV_IDLE;
            if (hsel && htrans[1]) begin
               st_next.fsm   = RTV_DATA;
               st_next.wr    = hwrite;
               st_next.addr  = haddr[11:0];
               st_next.ready = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '{fsm: RTV_IDLE, wr: 1'b0, addr: 12'h000,
                     rdata: RTV_RDATA_RST, ready: 1'b1};
      end else begin
         st_reg <= st_next;
      end
   end

   assign hrdata    = st_reg.rdata;
   assign hreadyout = st_reg.ready;

endmodule

// File: src/rtv_value_reg.sv
`timescale 1ns/1ns
module rtv_value_reg
   import rtv_pkg::*;
#(
   parameter logic [15:0] MASK = RTV_MASK_MINSEC
)(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // Software write
   input  wire logic        sw_wr,
   input  wire logic [15:0] sw_data,
   // Hardware update from the counters
   input  wire logic        hw_wr,
   input  wire logic [15:0] hw_data,
   // Stored value
   output logic [15:0]      value
);

   typedef struct packed {
      logic [15:0] value;
   } rtv_val_t;

   rtv_val_t st_reg;
   rtv_val_t st_next;

   // Software write beats a counter update in the same cycle
   always_comb begin
      st_next = st_reg;
      if (sw_wr) begin
         st_next.value = sw_data & MASK; // [R10]
      end else if (hw_wr) begin
         st_next.value = hw_data & MASK; // [R10]
      end
   end

   // Zero only as a convenience; software may not rely on it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '{value: RTV_VALUE_RST}; // [R11]
      end else begin
         st_reg <= st_next;
      end
   end

   assign value = st_reg.value;

endmodule

// File: src/rtv_window_top.sv
// Notes on behaviour
// [R1] Time pointer 00 shows minutes at 14-8
// [R2] Seconds digits at bits 6-4 and 3-0
// [R3] Alarm month tens bit 12, ones 11-8
// [R4] Alarm day tens 5-4, ones 3-0
// [R5] Alarm weekday digit at bits 10-8
// [R6] Alarm hour tens 5-4, ones 3-0
// [R7] Alarm date/weekday writes need write enable
// [R8] Alarm pointer selects register behind window
// [R9] Alarm minutes/seconds match time layout
// [R10] Unimplemented bits read zero, store nothing
// [R11] Value fields have no defined reset contents
// [R12] Upper byte access decrements alarm pointer; code steps on every access at offset 008 whatever hsize, stopping at 00
// [R13] Software writes only valid BCD digits
`timescale 1ns/1ns
module rtv_window_top
   import rtv_pkg::*;
(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Counter update of current minutes and seconds
   input  wire logic        time_update,
   input  wire logic [15:0] time_update_value,
   // Pointers and enable to the rest of the unit
   output logic [1:0]       time_window_pointer,
   output logic [1:0]       alarm_window_pointer,
   output logic             clock_write_enable,
   // Stored values to the compare and mask logic
   output logic [15:0]      time_minsec,
   output logic [15:0]      alarm_month_day,
   output logic [15:0]      alarm_weekday_hours,
   output logic [15:0]      alarm_minsec,
   output logic             alarm_minsec_match
);

   typedef struct packed {
      logic       wren;
      logic [1:0] aptr;
      logic [1:0] tptr;
      logic       match;
      logic       resp;
   } rtv_core_t;

   rtv_core_t st_reg;
   rtv_core_t st_next;

   rtv_req_if req ();

   logic        wr_ctrl;
   logic        wr_time;
   logic        acc_alarm;
   logic        wr_alarm;
   logic        wr_a_minsec;
   logic        wr_a_wdhr;
   logic        wr_a_mthday;
   logic [15:0] alarm_view;
   logic [15:0] time_view;
   logic [3:0]  valid_flags;
   logic [31:0] ctrl_view;
   logic [31:0] status_view;

   // Bus front end
   rtv_ahb_front u_front (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hready    (hready),
      .hwdata    (hwdata),
      .hrdata    (hrdata),
      .hreadyout (hreadyout),
      .req       (req.front)
   );

   // Decode of the request from the front end
   assign wr_ctrl   = req.req_wr && (req.addr == RTV_OFF_CTRL);
   assign wr_time   = req.req_wr && (req.addr == RTV_OFF_TIME)
                      && (st_reg.tptr == RTV_PTR_MINSEC); // [R1]
   assign acc_alarm = (req.req_wr || req.req_rd) && (req.addr == RTV_OFF_ALARM);
   assign wr_alarm  = req.req_wr && (req.addr == RTV_OFF_ALARM);

   // Writes land only in the register the pointer names
   assign wr_a_minsec = wr_alarm && (st_reg.aptr == RTV_PTR_MINSEC); // [R8]
   assign wr_a_wdhr   = wr_alarm && (st_reg.aptr == RTV_PTR_WDHR)
                        && st_reg.wren; // [R7]
   assign wr_a_mthday = wr_alarm && (st_reg.aptr == RTV_PTR_MTHDAY)
                        && st_reg.wren; // [R7]

   // Current minutes and seconds
   rtv_value_reg #(.MASK(RTV_MASK_MINSEC)) u_time_minsec (
      .hclk    (hclk),
      .hresetn (hresetn),
      .sw_wr   (wr_time),
      .sw_data (req.wdata[15:0]),
      .hw_wr   (time_update),
      .hw_data (time_update_value),
      .value   (time_minsec)
   ); // [R1] [R2]

   // Alarm minutes and seconds, same layout as the time
   rtv_value_reg #(.MASK(RTV_MASK_MINSEC)) u_alarm_minsec (
      .hclk    (hclk),
      .hresetn (hresetn),
      .sw_wr   (wr_a_minsec),
      .sw_data (req.wdata[15:0]),
      .hw_wr   (1'b0),
      .hw_data (RTV_VALUE_RST),
      .value   (alarm_minsec)
   ); // [R9]

   // Alarm weekday and hours
   rtv_value_reg #(.MASK(RTV_MASK_WDHR)) u_alarm_wdhr (
      .hclk    (hclk),
      .hresetn (hresetn),
      .sw_wr   (wr_a_wdhr),
      .sw_data (req.wdata[15:0]),
      .hw_wr   (1'b0),
      .hw_data (RTV_VALUE_RST),
      .value   (alarm_weekday_hours)
   ); // [R5] [R6]

   // Alarm month and day
   rtv_value_reg #(.MASK(RTV_MASK_MTHDAY)) u_alarm_mthday (
      .hclk    (hclk),
      .hresetn (hresetn),
      .sw_wr   (wr_a_mthday),
      .sw_data (req.wdata[15:0]),
      .hw_wr   (1'b0),
      .hw_data (RTV_VALUE_RST),
      .value   (alarm_month_day)
   ); // [R3] [R4]

   // BCD digit check: flags only, values are never corrected
   function automatic logic digit_ok(input logic [3:0] d, input logic [3:0] max);
      digit_ok = (d <= max);
   endfunction

   always_comb begin
      valid_flags[0] =
         digit_ok({1'b0, time_minsec[RTV_MIN_TEN_POS +: 3]}, 4'h5) &&
         digit_ok(time_minsec[RTV_MIN_ONE_POS +: 4], 4'h9) &&
         digit_ok({1'b0, time_minsec[RTV_SEC_TEN_POS +: 3]}, 4'h5) &&
         digit_ok(time_minsec[RTV_SEC_ONE_POS +: 4], 4'h9); // [R13]
      valid_flags[1] =
         digit_ok({1'b0, alarm_minsec[RTV_MIN_TEN_POS +: 3]}, 4'h5) &&
         digit_ok(alarm_minsec[RTV_MIN_ONE_POS +: 4], 4'h9) &&
         digit_ok({1'b0, alarm_minsec[RTV_SEC_TEN_POS +: 3]}, 4'h5) &&
         digit_ok(alarm_minsec[RTV_SEC_ONE_POS +: 4], 4'h9);
      valid_flags[2] =
         digit_ok({1'b0, alarm_weekday_hours[RTV_WEEKDAY_DIGIT_POS +: 3]}, 4'h6) &&
         digit_ok({2'b00, alarm_weekday_hours[RTV_HR_TEN_POS +: 2]}, 4'h2) &&
         digit_ok(alarm_weekday_hours[RTV_HR_ONE_POS +: 4], 4'h9);
      valid_flags[3] =
         digit_ok(alarm_month_day[RTV_MTH_ONE_POS +: 4], 4'h9) &&
         digit_ok({2'b00, alarm_month_day[RTV_DAY_TEN_POS +: 2]}, 4'h3) &&
         digit_ok(alarm_month_day[RTV_DAY_ONE_POS +: 4], 4'h9) &&
         (alarm_month_day[RTV_MTH_TEN_POS] == 1'b0 ||
          alarm_month_day[RTV_MTH_ONE_POS +: 4] <= 4'h2);
   end

   // Read views of the windows
   always_comb begin
      alarm_view = 16'h0000; // [R10]
      unique case (st_reg.aptr) // [R8]
         RTV_PTR_MINSEC: alarm_view = alarm_minsec;
         RTV_PTR_WDHR:   alarm_view = alarm_weekday_hours;
         RTV_PTR_MTHDAY: alarm_view = alarm_month_day;
         default:        alarm_view = 16'h0000;
      endcase
      // Other time pointer values belong to registers outside this block
      time_view = (st_reg.tptr == RTV_PTR_MINSEC) ? time_minsec : 16'h0000; // [R1]
      ctrl_view = 32'h0000_0000;
      ctrl_view[RTV_CTRL_WREN_POS]      = st_reg.wren;
      ctrl_view[RTV_CTRL_APTR_POS +: 2] = st_reg.aptr;
      ctrl_view[RTV_CTRL_TPTR_POS +: 2] = st_reg.tptr;
      status_view = 32'h0000_0000;
      status_view[RTV_STAT_VALID_POS +: 4] = valid_flags;
      status_view[RTV_STAT_MATCH_POS]      = st_reg.match;
   end

   // Read data back to the front end; unmapped reads give zero
   always_comb begin
      unique case (req.addr)
         RTV_OFF_CTRL:   req.rdata = ctrl_view;
         RTV_OFF_TIME:   req.rdata = {16'h0000, time_view};
         RTV_OFF_ALARM:  req.rdata = {16'h0000, alarm_view};
         RTV_OFF_STATUS: req.rdata = status_view;
         default:        req.rdata = 32'h0000_0000;
      endcase
   end

   // Control state, pointer stepping and compare
   always_comb begin
      st_next = st_reg;
      if (wr_ctrl) begin
         st_next.wren = req.wdata[RTV_CTRL_WREN_POS];
         st_next.aptr = req.wdata[RTV_CTRL_APTR_POS +: 2];
         st_next.tptr = req.wdata[RTV_CTRL_TPTR_POS +: 2];
      end
      // hsize is not decoded; any access at the alarm offset counts as an upper byte access
      if (acc_alarm && st_reg.aptr != RTV_PTR_MINSEC) begin
         st_next.aptr = st_reg.aptr - 2'h1; // [R12]
      end
      // Compare of stored minutes and seconds for the mask logic
      st_next.match = (time_minsec == alarm_minsec);
      st_next.resp  = 1'b0;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '{wren: RTV_WREN_RST, aptr: RTV_PTR_RST, tptr: RTV_PTR_RST,
                     match: 1'b0, resp: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign hresp                = st_reg.resp;
   assign time_window_pointer  = st_reg.tptr;
   assign alarm_window_pointer = st_reg.aptr;
   assign clock_write_enable   = st_reg.wren;
   assign alarm_minsec_match   = st_reg.match;

endmodule

// File: sim/rtv_window_checker.sv
`timescale 1ns/1ns
module rtv_window_checker
   import rtv_pkg::*;
(
   // Clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // Bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   // Counter update
   input wire logic        time_update,
   input wire logic [15:0] time_update_value,
   // Window state
   input wire logic [1:0]  alarm_window_pointer,
   input wire logic        clock_write_enable,
   input wire logic [15:0] time_minsec,
   input wire logic [15:0] alarm_month_day,
   input wire logic [15:0] alarm_weekday_hours,
   input wire logic [15:0] alarm_minsec
);
   logic       take;
   logic       al_ph;
   logic       aw_ph;
   logic       tw_ph;
   logic [1:0] ptr_exp;
   assign take = hsel && hready && htrans[1];
   // Pointer captured at the address edge, before any step
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         al_ph   <= 1'b0;
         aw_ph   <= 1'b0;
         tw_ph   <= 1'b0;
         ptr_exp <= 2'h0;
      end else begin
         al_ph <= take && haddr[11:0] == RTV_OFF_ALARM;
         aw_ph <= take && hwrite && haddr[11:0] == RTV_OFF_ALARM;
         tw_ph <= take && hwrite && haddr[11:0] == RTV_OFF_TIME;
         if (take)
            ptr_exp <= (alarm_window_pointer == 2'h0) ? 2'h0 : alarm_window_pointer - 2'h1;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_tm_bits; (time_minsec & ~RTV_MASK_MINSEC) == 16'h0000; endproperty
   a_tm_bits: assert property (p_tm_bits) else $error("time value has stray bits");
   property p_md_bits; (alarm_month_day & ~RTV_MASK_MTHDAY) == 16'h0000; endproperty
   a_md_bits: assert property (p_md_bits) else $error("month/day has stray bits");
   property p_wh_bits; (alarm_weekday_hours & ~RTV_MASK_WDHR) == 16'h0000; endproperty
   a_wh_bits: assert property (p_wh_bits) else $error("weekday/hours has stray bits");
   property p_am_bits; (alarm_minsec & ~RTV_MASK_MINSEC) == 16'h0000; endproperty
   a_am_bits: assert property (p_am_bits) else $error("alarm min/sec has stray bits");
   property p_locked;
      aw_ph && !clock_write_enable |=> $stable(alarm_month_day) && $stable(alarm_weekday_hours);
   endproperty
   a_locked: assert property (p_locked) else $error("locked alarm register changed");
   property p_step; al_ph |-> ##[0:1] alarm_window_pointer == ptr_exp; endproperty
   a_step: assert property (p_step) else $error("alarm pointer did not step");
   property p_wait; take |=> !hreadyout ##1 hreadyout; endproperty
   a_wait: assert property (p_wait) else $error("bus answer out of time");
   property p_load;
      time_update && !tw_ph |=> time_minsec == ($past(time_update_value) & RTV_MASK_MINSEC);
   endproperty
   a_load: assert property (p_load) else $error("counter update not loaded");
   property p_hi; hrdata[31:16] == 16'h0000; endproperty
   a_hi: assert property (p_hi) else $error("upper read half not zero");
endmodule

bind rtv_window_top rtv_window_checker u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .time_update(time_update), .time_update_value(time_update_value),
   .alarm_window_pointer(alarm_window_pointer), .clock_write_enable(clock_write_enable),
   .time_minsec(time_minsec), .alarm_month_day(alarm_month_day),
   .alarm_weekday_hours(alarm_weekday_hours), .alarm_minsec(alarm_minsec)
);

// File: sim/testbench.sv
`timescale 1ns/1ns
module testbench
   import rtv_pkg::*;
;
   typedef struct packed {
      logic [31:0] ctrl;
      logic [11:0] addr;
      logic [31:0] wd;
      logic [31:0] exp;
   } rtv_row_t;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        time_update = 1'b0;
   logic [15:0] time_update_value = 16'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [1:0]  tptr;
   logic [1:0]  aptr;
   logic        wren;
   logic [15:0] t_ms;
   logic [15:0] a_md;
   logic [15:0] a_wh;
   logic [15:0] a_ms;
   logic [31:0] rd_q;
   logic        mt;
   int          n_errors = 0;
   int          samples_checked = 0;
   // Unused field bits set high so stray storage shows, except in the two locked-write rows
   rtv_row_t rows [7] = '{
      '{32'h0000_0201, RTV_OFF_ALARM, 32'hFFFF_F2F1, 32'h0000_1231},
      '{32'h0000_0101, RTV_OFF_ALARM, 32'hFFFF_FEE3, 32'h0000_0623},
      '{32'h0000_0001, RTV_OFF_ALARM, 32'hFFFF_D9D8, 32'h0000_5958},
      '{32'h0000_0000, RTV_OFF_TIME,  32'hFFFF_C5B7, 32'h0000_4537},
      '{32'h0000_0200, RTV_OFF_ALARM, 32'h0000_0101, 32'h0000_1231},
      '{32'h0000_0100, RTV_OFF_ALARM, 32'h0000_0101, 32'h0000_0623},
      '{32'h0000_0300, RTV_OFF_ALARM, 32'hFFFF_FFFF, 32'h0000_0000}};
   logic [31:0] rseq [4] = '{32'h0000_1231, 32'h0000_0623, 32'h0000_5958, 32'h0000_5958};
   logic [31:0] wseq [3] = '{32'h0000_0115, 32'h0000_0308, 32'h0000_1000};

   always #5 hclk = ~hclk;

   rtv_window_top DUT (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .time_update(time_update), .time_update_value(time_update_value),
      .time_window_pointer(tptr), .alarm_window_pointer(aptr),
      .clock_write_enable(wren), .time_minsec(t_ms), .alarm_month_day(a_md),
      .alarm_weekday_hours(a_wh), .alarm_minsec(a_ms), .alarm_minsec_match(mt)
   );

   task test_done;
      if (n_errors == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Ready and read data taken at the rising edge, before the flops move
   task wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      rd_q = hrdata;
      if (hreadyout !== 1'b1) begin
         n_errors++;
         $display("MISMATCH %0t bus hang", $time);
         test_done();
      end
   endtask

   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {20'h00000, a};
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
   endtask

   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      // Pointer reloaded before the read, as every alarm access from a nonzero pointer steps it
      for (int i = 0; i < 7; i++) begin
         xfer(1'b1, RTV_OFF_CTRL, rows[i].ctrl);
         xfer(1'b1, rows[i].addr, rows[i].wd);
         xfer(1'b1, RTV_OFF_CTRL, rows[i].ctrl);
         xfer(1'b0, rows[i].addr, 32'h0);
         chk(rd_q, rows[i].exp);
      end
      xfer(1'b1, RTV_OFF_CTRL, 32'h0000_0201);
      for (int i = 0; i < 4; i++) begin
         xfer(1'b0, RTV_OFF_ALARM, 32'h0);
         chk(rd_q, rseq[i]);
      end
      chk({30'h0, aptr}, 32'h0);
      xfer(1'b1, RTV_OFF_CTRL, 32'h0000_0201);
      for (int i = 0; i < 3; i++)
         xfer(1'b1, RTV_OFF_ALARM, wseq[i]);
      @(negedge hclk);
      chk({a_md, a_wh}, {wseq[0][15:0], wseq[1][15:0]});
      chk({16'h0, a_ms}, wseq[2]);
      @(posedge hclk);
      time_update       <= 1'b1;
      time_update_value <= 16'hB2C5;
      @(posedge hclk);
      time_update <= 1'b0;
      xfer(1'b0, RTV_OFF_TIME, 32'h0);
      chk(rd_q, 32'h0000_3245);
      xfer(1'b1, RTV_OFF_CTRL, 32'h0001_0000);
      xfer(1'b0, RTV_OFF_TIME, 32'h0);
      chk(rd_q, 32'h0);
      xfer(1'b1, 12'h010, 32'hFFFF_FFFF);
      xfer(1'b0, 12'h010, 32'h0);
      chk(rd_q, 32'h0);
      // Reset mid-run; stored values may be anything after it
      xfer(1'b1, RTV_OFF_CTRL, 32'h0000_0201);
      @(posedge hclk);
      hresetn <= 1'b0;
      @(negedge hclk);
      chk({29'h0, wren, aptr}, 32'h0);
      @(posedge hclk);
      hresetn <= 1'b1;
      xfer(1'b1, RTV_OFF_ALARM, 32'h0000_0101);
      xfer(1'b0, RTV_OFF_ALARM, 32'h0);
      chk(rd_q, 32'h0000_0101);
      // Status: all digits valid, minutes/seconds differ
      xfer(1'b0, RTV_OFF_STATUS, 32'h0);
      chk(rd_q, 32'h0000_000F);
      chk({31'h0, mt}, 32'h0);
      xfer(1'b1, RTV_OFF_TIME, 32'h0000_0101);
      repeat (2) @(posedge hclk);
      xfer(1'b0, RTV_OFF_STATUS, 32'h0);
      chk(rd_q, 32'h0000_010F);
      chk({31'h0, mt}, 32'h1);
      chk({31'h0, hresp}, 32'h0);
      test_done();
   end
endmodule
